// file: design/asrt_pkg.sv
// asrt_pkg: bus carriers, line settings and state types of the serial buffers
// assumes the offsets and bit positions come from asrt_regs.svh
package asrt_pkg;
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } asrt_axi_req_type;
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } asrt_axi_rsp_type;
   typedef struct packed {
      logic [1:0] len;
      logic par_en;
      logic par_even;
   } asrt_line_type;
   typedef enum logic [2:0] {ph_idle, ph_start, ph_data, ph_par, ph_stop} asrt_phase_type;
   typedef struct packed {
      logic done;
      logic frame;
      logic parity;
      logic [7:0] data;
   } asrt_rx_out_type;
   typedef struct packed {
      asrt_phase_type ph;
      logic [3:0] cnt;
      logic [2:0] bi;
      logic [7:0] sh;
      asrt_rx_out_type o;
   } asrt_rx_st_type;
   typedef struct packed {
      asrt_phase_type ph;
      logic [3:0] cnt;
      logic [2:0] bi;
      logic [7:0] sh;
      logic pbit;
      logic line;
   } asrt_tx_st_type;
   typedef struct packed {
      asrt_axi_rsp_type rsp;
      logic aw_ok;
      logic w_ok;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic rx_done;
      logic rie;
      logic over;
      logic frame;
      logic parity;
      logic [7:0] rx_data;
      logic tie;
      logic brk;
      logic hold_full;
      logic [7:0] hold_data;
      asrt_line_type cfg;
      logic sync_mode;
      logic prst;
      logic [15:0] div;
      logic [15:0] dcnt;
      logic tick;
      logic txd;
      logic rx_irq;
      logic tx_irq;
   } asrt_top_st_type;

   // index of the last character bit: 5..8 bits
   function automatic logic [2:0] asrt_last_bit(input asrt_line_type c);
      return 3'(3'h4 + {1'b0, c.len});
   endfunction : asrt_last_bit

   function automatic logic asrt_par_on(input asrt_line_type c);
      return c.par_en && (c.len != 2'h3); // [R10]
   endfunction : asrt_par_on

   function automatic logic [7:0] asrt_mask(input asrt_line_type c);
      return 8'(8'hff >> (2'h3 - c.len));
   endfunction : asrt_mask
endpackage : asrt_pkg

// file: design/asrt_regs.svh
// asrt_regs.svh: offsets, bit positions, reset values and timing counts
// assumes a 250 MHz aclk and a 32-bit AXI4-Lite register port
// Functional notes
// (R1) error bit is OR of three error flags
// (R2) error bit never raises an interrupt request
// (R3) error clears when cause gone or buffer read
// (R4) overrun when char completes with done still set
// (R5) framing flag when stop bit is not mark
// (R6) init clears error, overrun and framing flags
// (R7) parity flag on mismatch, zero when disabled
// (R8) short characters right-justified, data survives init
// (R9) parity bit sits just above character bits
// (R10) eight-bit characters carry no parity
// (R11) reading receive buffer clears receiver done
// (R12) transmitter ready when buffer free, set by init
// (R13) ready with enable raises transmit request
// (R14) break bit holds line at space continuously
// (R15) software writes short characters right-justified
// (R16) programmed reset forces asynchronous mode, clears flags
// (R17) software raises priority before clearing enables
// (R18) receiver done with enable raises receive request
`ifndef ASRT_REGS_SVH
`define ASRT_REGS_SVH
`define ASRT_OFF_RX_CTRL 32'h0000_0000
`define ASRT_OFF_RX_BUF 32'h0000_0004
`define ASRT_OFF_TX_CTRL 32'h0000_0008
`define ASRT_OFF_TX_BUF 32'h0000_000c
`define ASRT_OFF_LINE 32'h0000_0010
`define ASRT_OFF_DIV 32'h0000_0014
`define ASRT_B_ERR 15
`define ASRT_B_OVER 14
`define ASRT_B_FRAME 13
`define ASRT_B_PARITY 12
`define ASRT_B_DONE 7
`define ASRT_B_RIE 6
`define ASRT_B_TRDY 7
`define ASRT_B_TIE 6
`define ASRT_B_BRK 0
`define ASRT_B_LEN 0
`define ASRT_B_PEN 2
`define ASRT_B_PEVEN 3
`define ASRT_B_SYNC 4
`define ASRT_B_PRST 8
`define ASRT_LEN_RST 2'h3
`define ASRT_CLK_HZ 250000000
`define ASRT_BAUD_RST 9600
`define ASRT_OVS 16
`define ASRT_DIV_RST (`ASRT_CLK_HZ / (`ASRT_OVS * `ASRT_BAUD_RST))
`define ASRT_RESP_OK 2'h0
`define ASRT_RESP_ERR 2'h2
`endif

// file: design/asrt_rx.sv
// asrt_rx: 16x oversampled asynchronous character receiver
// assumes rxd is synchronous to aclk and tick is a one-cycle enable
`timescale 1ns/10ps
module asrt_rx
   import asrt_pkg::*;
(
   input wire logic aclk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic rxd,
   input wire asrt_line_type cfg,
   output asrt_rx_out_type rx_o
);
   asrt_rx_st_type st_q;
   asrt_rx_st_type st_d;

   always_comb begin
      logic [2:0] last;
      last = asrt_last_bit(cfg);
      st_d = st_q;
      st_d.o.done = 1'b0;
      if (tick) begin
         st_d.cnt = st_q.cnt + 4'h1;
         case (st_q.ph)
            ph_idle: begin
               st_d.cnt = 4'h0;
               if (!rxd) begin
                  st_d.ph = ph_start;
               end
            end
            ph_start: begin
               // confirm start at mid bit so glitches do not start a character
               if (st_q.cnt == 4'h7) begin
                  st_d.cnt = 4'h0;
                  st_d.bi = 3'h0;
                  st_d.sh = 8'h00;
                  st_d.ph = rxd ? ph_idle : ph_data;
               end
            end
            ph_data: begin
               if (st_q.cnt == 4'hf) begin
                  st_d.sh[st_q.bi] = rxd; // [R8]
                  st_d.bi = st_q.bi + 3'h1;
                  if (st_q.bi == last) begin
                     st_d.ph = asrt_par_on(cfg) ? ph_par : ph_stop; // [R10]
                  end
               end
            end
            ph_par: begin
               if (st_q.cnt == 4'hf) begin
                  st_d.sh[3'(last + 3'h1)] = rxd; // [R9]
                  st_d.ph = ph_stop;
               end
            end
            ph_stop: begin
               if (st_q.cnt == 4'hf) begin
                  st_d.o.done = 1'b1;
                  st_d.o.data = st_q.sh;
                  st_d.o.frame = ~rxd; // [R5]
                  // sh holds data and parity only, so its xor is the check
                  st_d.o.parity = asrt_par_on(cfg) & (cfg.par_even ? ^st_q.sh : ~^st_q.sh); // [R7]
                  st_d.ph = ph_idle;
               end
            end
            default: st_d.ph = ph_idle;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rx_o = st_q.o;
endmodule : asrt_rx

// file: design/asrt_top.sv
// asrt_top: receive buffer with error flags, transmit control and buffer
// assumes an AXI4-Lite master on aclk; rxd/txd are mark-high serial lines
`timescale 1ns/10ps
`include "asrt_regs.svh"
module asrt_top
   import asrt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire asrt_axi_req_type s_axi_req,
   output asrt_axi_rsp_type s_axi_rsp,
   input wire logic rxd,
   output logic txd,
   output logic rx_irq,
   output logic tx_irq,
   output logic sync_mode
);
   asrt_top_st_type st_q;
   asrt_top_st_type st_d;
   asrt_rx_out_type rx_o;
   logic tx_busy;
   logic tx_line;
   logic launch;
   logic sub_rst_n;

   function automatic logic addr_ok(input logic [31:0] a);
      case (a)
         `ASRT_OFF_RX_CTRL, `ASRT_OFF_RX_BUF, `ASRT_OFF_TX_CTRL,
         `ASRT_OFF_TX_BUF, `ASRT_OFF_LINE, `ASRT_OFF_DIV: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : addr_ok

   // programmed reset also restarts both shifters
   assign sub_rst_n = aresetn & ~st_q.prst; // [R16]
   assign launch = st_q.hold_full & ~tx_busy;

   asrt_rx u_rx (
      .aclk(aclk),
      .rst_n(sub_rst_n),
      .tick(st_q.tick),
      .rxd(rxd),
      .cfg(st_q.cfg),
      .rx_o(rx_o)
   );

   asrt_tx u_tx (
      .aclk(aclk),
      .rst_n(sub_rst_n),
      .tick(st_q.tick),
      .start(launch),
      .data(st_q.hold_data),
      .cfg(st_q.cfg),
      .busy(tx_busy),
      .line(tx_line)
   );

   always_comb begin
      logic aw_hs;
      logic w_hs;
      logic ar_hs;
      logic rd_buf;
      logic [15:0] rv;
      logic [31:0] wd;
      logic [3:0] ws;
      aw_hs = s_axi_req.awvalid & st_q.rsp.awready;
      w_hs = s_axi_req.wvalid & st_q.rsp.wready;
      ar_hs = s_axi_req.arvalid & st_q.rsp.arready;
      rd_buf = ar_hs && (s_axi_req.araddr == `ASRT_OFF_RX_BUF);
      rv = 16'h0000;
      wd = st_q.wdata;
      ws = st_q.wstrb;
      st_d = st_q;

      // baud enable at 16x the bit rate; a zero divisor ticks every cycle
      st_d.tick = 1'b0;
      if (st_q.div == 16'h0000 || st_q.dcnt >= st_q.div - 16'h0001) begin
         st_d.dcnt = 16'h0000;
         st_d.tick = 1'b1;
      end else begin
         st_d.dcnt = st_q.dcnt + 16'h0001;
      end

      // programmed reset pulse: flags and enables cleared, async mode again
      st_d.prst = 1'b0;
      if (st_q.prst) begin
         st_d.rx_done = 1'b0;
         st_d.rie = 1'b0;
         st_d.over = 1'b0; // [R16]
         st_d.frame = 1'b0;
         st_d.parity = 1'b0;
         st_d.tie = 1'b0;
         st_d.brk = 1'b0;
         st_d.hold_full = 1'b0;
         st_d.sync_mode = 1'b0; // [R16]
      end

      // transmit holding register hands its character to the shifter
      if (launch) begin
         st_d.hold_full = 1'b0; // [R12]
      end

      // read channel
      case (s_axi_req.araddr)
         `ASRT_OFF_RX_CTRL: begin
            rv[`ASRT_B_DONE] = st_q.rx_done;
            rv[`ASRT_B_RIE] = st_q.rie;
         end
         `ASRT_OFF_RX_BUF: begin
            rv[`ASRT_B_OVER] = st_q.over;
            rv[`ASRT_B_FRAME] = st_q.frame;
            rv[`ASRT_B_PARITY] = st_q.parity & asrt_par_on(st_q.cfg); // [R7]
            rv[`ASRT_B_ERR] = st_q.over | st_q.frame | rv[`ASRT_B_PARITY]; // [R1]
            rv[7:0] = st_q.rx_data; // [R8]
         end
         `ASRT_OFF_TX_CTRL: begin
            rv[`ASRT_B_TRDY] = ~st_q.hold_full; // [R12]
            rv[`ASRT_B_TIE] = st_q.tie;
            rv[`ASRT_B_BRK] = st_q.brk;
         end
         `ASRT_OFF_LINE: begin
            rv[`ASRT_B_LEN +: 2] = st_q.cfg.len;
            rv[`ASRT_B_PEN] = st_q.cfg.par_en;
            rv[`ASRT_B_PEVEN] = st_q.cfg.par_even;
            rv[`ASRT_B_SYNC] = st_q.sync_mode;
         end
         `ASRT_OFF_DIV: rv = st_q.div;
         default: rv = 16'h0000;
      endcase
      if (st_q.rsp.rvalid && s_axi_req.rready) begin
         st_d.rsp.rvalid = 1'b0;
      end
      if (ar_hs) begin
         st_d.rsp.rvalid = 1'b1;
         st_d.rsp.rdata = {16'h0000, rv};
         st_d.rsp.rresp = addr_ok(s_axi_req.araddr) ? `ASRT_RESP_OK : `ASRT_RESP_ERR;
      end
      if (rd_buf) begin
         st_d.rx_done = 1'b0; // [R11]
         st_d.over = 1'b0; // [R3]
         st_d.frame = 1'b0;
         st_d.parity = 1'b0;
      end

      // a completed character wins over a read in the same cycle
      if (rx_o.done) begin
         if (st_q.rx_done && !rd_buf) begin
            st_d.over = 1'b1; // [R4]
         end
         st_d.frame = rx_o.frame; // [R5]
         st_d.parity = rx_o.parity; // [R7]
         st_d.rx_data = rx_o.data; // [R9]
         st_d.rx_done = 1'b1; // [R18]
      end

      // write channel: address and data taken in either order
      if (st_q.rsp.bvalid && s_axi_req.bready) begin
         st_d.rsp.bvalid = 1'b0;
      end
      if (aw_hs) begin
         st_d.aw_ok = 1'b1;
         st_d.awaddr = s_axi_req.awaddr;
      end
      if (w_hs) begin
         st_d.w_ok = 1'b1;
         st_d.wdata = s_axi_req.wdata;
         st_d.wstrb = s_axi_req.wstrb;
      end
      if (st_q.aw_ok && st_q.w_ok && !st_q.rsp.bvalid) begin
         st_d.aw_ok = 1'b0;
         st_d.w_ok = 1'b0;
         st_d.rsp.bvalid = 1'b1;
         st_d.rsp.bresp = addr_ok(st_q.awaddr) ? `ASRT_RESP_OK : `ASRT_RESP_ERR;
         case (st_q.awaddr)
            `ASRT_OFF_RX_CTRL: begin
               if (ws[0]) begin
                  st_d.rie = wd[`ASRT_B_RIE];
               end
            end
            `ASRT_OFF_TX_CTRL: begin
               if (ws[0]) begin
                  st_d.tie = wd[`ASRT_B_TIE];
                  st_d.brk = wd[`ASRT_B_BRK]; // [R14]
               end
            end
            `ASRT_OFF_TX_BUF: begin
               if (ws[0]) begin
                  // upper bits dropped so a careless write cannot widen a short char
                  st_d.hold_data = wd[7:0] & asrt_mask(st_q.cfg); // [R15]
                  st_d.hold_full = 1'b1;
               end
            end
            `ASRT_OFF_LINE: begin
               if (ws[0]) begin
                  st_d.cfg.len = wd[`ASRT_B_LEN +: 2];
                  st_d.cfg.par_en = wd[`ASRT_B_PEN];
                  st_d.cfg.par_even = wd[`ASRT_B_PEVEN];
                  st_d.sync_mode = wd[`ASRT_B_SYNC];
               end
               if (ws[1] && wd[`ASRT_B_PRST]) begin
                  st_d.prst = 1'b1; // [R16]
               end
            end
            `ASRT_OFF_DIV: begin
               if (ws[0]) begin
                  st_d.div[7:0] = wd[7:0];
               end
               if (ws[1]) begin
                  st_d.div[15:8] = wd[15:8];
               end
            end
            default: st_d.rsp.bvalid = 1'b1;
         endcase
      end
      st_d.rsp.awready = ~st_d.aw_ok & ~st_d.rsp.bvalid;
      st_d.rsp.wready = ~st_d.w_ok & ~st_d.rsp.bvalid;
      st_d.rsp.arready = ~st_d.rsp.rvalid;

      // request levels; error flags deliberately kept out of them
      st_d.rx_irq = st_d.rx_done & st_d.rie; // [R18] [R2]
      st_d.tx_irq = ~st_d.hold_full & st_d.tie; // [R13]
      st_d.txd = st_d.brk ? 1'b0 : tx_line; // [R14]
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0; // [R6] [R12]
         st_q.rx_data <= st_q.rx_data; // [R8]
         st_q.rsp.awready <= 1'b1;
         st_q.rsp.wready <= 1'b1;
         st_q.rsp.arready <= 1'b1;
         st_q.txd <= 1'b1;
         st_q.div <= 16'(`ASRT_DIV_RST);
         st_q.cfg.len <= `ASRT_LEN_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_rsp = st_q.rsp;
   assign txd = st_q.txd;
   assign rx_irq = st_q.rx_irq;
   assign tx_irq = st_q.tx_irq;
   assign sync_mode = st_q.sync_mode;
endmodule : asrt_top

// file: design/asrt_tx.sv
// asrt_tx: 16x paced asynchronous character transmitter
// assumes start is only raised while busy is low
`timescale 1ns/10ps
module asrt_tx
   import asrt_pkg::*;
(
   input wire logic aclk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic start,
   input wire logic [7:0] data,
   input wire asrt_line_type cfg,
   output logic busy,
   output logic line
);
   asrt_tx_st_type st_q;
   asrt_tx_st_type st_d;

   always_comb begin
      st_d = st_q;
      if (st_q.ph == ph_idle) begin
         if (start) begin
            st_d.sh = data & asrt_mask(cfg);
            st_d.pbit = cfg.par_even ? ^(data & asrt_mask(cfg)) : ~^(data & asrt_mask(cfg));
            st_d.cnt = 4'h0;
            st_d.line = 1'b0;
            st_d.ph = ph_start;
         end
      end else if (tick) begin
         st_d.cnt = st_q.cnt + 4'h1;
         if (st_q.cnt == 4'hf) begin
            case (st_q.ph)
               ph_start: begin
                  st_d.bi = 3'h0;
                  st_d.line = st_q.sh[0];
                  st_d.ph = ph_data;
               end
               ph_data: begin
                  st_d.bi = st_q.bi + 3'h1;
                  st_d.line = st_q.sh[3'(st_q.bi + 3'h1)];
                  if (st_q.bi == asrt_last_bit(cfg)) begin
                     st_d.ph = asrt_par_on(cfg) ? ph_par : ph_stop; // [R10]
                     st_d.line = asrt_par_on(cfg) ? st_q.pbit : 1'b1;
                  end
               end
               ph_par: begin
                  st_d.line = 1'b1;
                  st_d.ph = ph_stop;
               end
               ph_stop: st_d.ph = ph_idle;
               default: st_d.ph = ph_idle;
            endcase
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!rst_n) begin
         st_q <= '0;
         st_q.line <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign busy = (st_q.ph != ph_idle);
   assign line = st_q.line;
endmodule : asrt_tx

// file: tb/asrt_assertions.sv
// asrt_checker: port-level rules of the serial buffers
// assumes byte offsets of asrt_regs.svh and one access of each kind at a time
`timescale 1ns/10ps
`include "asrt_regs.svh"
module asrt_checker
   import asrt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire asrt_axi_req_type s_axi_req,
   input wire asrt_axi_rsp_type s_axi_rsp,
   input wire logic rxd,
   input wire logic txd,
   input wire logic rx_irq,
   input wire logic tx_irq,
   input wire logic sync_mode
);
   logic [31:0] ra_q, aw_q, wd_q;
   logic [3:0] ws_q;
   logic brk_q, pen_q;
   wire logic bhs = s_axi_rsp.bvalid && s_axi_req.bready;
   wire logic arh = s_axi_req.arvalid && s_axi_rsp.arready;
   wire logic rb = s_axi_rsp.rvalid && ra_q == `ASRT_OFF_RX_BUF;
   wire logic [15:0] rd = s_axi_rsp.rdata[15:0];
   wire logic prst = bhs && aw_q == `ASRT_OFF_LINE && ws_q[1] && wd_q[`ASRT_B_PRST];
   // shadow state follows the response handshake, a cycle or two behind the design
   always_ff @(posedge aclk) begin
      if (arh) ra_q <= s_axi_req.araddr;
      if (s_axi_req.awvalid && s_axi_rsp.awready) aw_q <= s_axi_req.awaddr;
      if (s_axi_req.wvalid && s_axi_rsp.wready) begin
         wd_q <= s_axi_req.wdata;
         ws_q <= s_axi_req.wstrb;
      end
      if (!aresetn || prst) brk_q <= 1'b0;
      else if (bhs && aw_q == `ASRT_OFF_TX_CTRL && ws_q[0]) brk_q <= wd_q[0];
      if (!aresetn) pen_q <= 1'b0;
      else if (bhs && aw_q == `ASRT_OFF_LINE && ws_q[0]) pen_q <= wd_q[2] && wd_q[1:0] != 2'h3;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_err_or;
      rb |-> rd[15] == |rd[14:12];
   endproperty
   a_err_or: assert property (p_err_or) else $error("summary flag wrong");
   property p_par_off;
      rb && !pen_q |-> !rd[12];
   endproperty
   a_par_off: assert property (p_par_off) else $error("parity flag without parity");
   property p_gap_zero;
      rb |-> rd[11:8] == 4'h0 && s_axi_rsp.rdata[31:16] == 16'h0;
   endproperty
   a_gap_zero: assert property (p_gap_zero) else $error("unused bits set");
   property p_rx_irq;
      s_axi_rsp.rvalid && ra_q == `ASRT_OFF_RX_CTRL && rd[7] && rd[6] |-> ##[0:2] rx_irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("rx request missing");
   property p_tx_irq;
      s_axi_rsp.rvalid && ra_q == `ASRT_OFF_TX_CTRL && rd[7] && rd[6] |-> ##[0:2] tx_irq;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx request missing");
   property p_rd_clr;
      arh && s_axi_req.araddr == `ASRT_OFF_RX_BUF && rx_irq |-> ##[1:4] !rx_irq;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("done not cleared by read");
   // the design drops break at the commit edge, a cycle before its response handshake
   property p_brk;
      brk_q && !(bhs && aw_q == `ASRT_OFF_TX_CTRL) |-> !txd;
   endproperty
   a_brk: assert property (p_brk) else $error("line not spacing in break");
   property p_prst;
      prst |-> ##[1:4] !sync_mode && !tx_irq && !rx_irq;
   endproperty
   a_prst: assert property (p_prst) else $error("programmed reset ignored");
   property p_init;
      $rose(aresetn) |-> txd && !rx_irq && !tx_irq && !sync_mode;
   endproperty
   a_init: assert property (p_init) else $error("state after init wrong");
   c_err: cover property (rb && rd[15]);
   c_brk: cover property (brk_q && !txd);
   c_prst: cover property (prst);
endmodule : asrt_checker

bind asrt_top asrt_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req),
   .s_axi_rsp(s_axi_rsp), .rxd(rxd), .txd(txd), .rx_irq(rx_irq), .tx_irq(tx_irq),
   .sync_mode(sync_mode));

// file: tb/asrt_line_model.sv
// asrt_line_model: far end of the serial line, frames onto rxd, decodes txd
// assumes the bench sets rx_len before each character it expects on txd
`timescale 1ns/10ps
module asrt_line_model #(
   parameter int BIT = 16
) (
   input wire logic aclk,
   input wire logic txd,
   output logic rxd
);
   logic [11:0] got;
   int rx_len = 10;
   int got_n = 0;
   int k;
   initial rxd = 1'b1;
   // last bit kept short so a bad stop bit cannot pose as a new start
   task automatic send(input logic [11:0] fr, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         rxd <= fr[i];
         repeat ((i == n - 1 ? BIT / 2 + 2 : BIT) - 1) @(posedge aclk);
      end
      @(posedge aclk);
      rxd <= 1'b1;
   endtask : send
   always begin
      @(posedge aclk iff txd === 1'b0);
      got = '1;
      repeat (BIT / 2) @(posedge aclk);
      for (k = 0; k < rx_len; k++) begin
         repeat (BIT) @(posedge aclk);
         got[k] = txd;
      end
      got_n++;
   end
endmodule : asrt_line_model

// file: tb/tb_top.sv
// tb_top: randomised self-checking bench for the serial buffers
// assumes divisor 1, so 16 clocks per serial bit
`timescale 1ns/10ps
`include "asrt_regs.svh"
module tb_top
   import asrt_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   asrt_axi_req_type req = '0;
   asrt_axi_rsp_type rsp;
   logic txd, rxd, rx_irq, tx_irq, sync_mode;
   int checks = 0;
   int fail_count = 0;
   logic [15:0] rnd = 16'h001f;
   logic [31:0] rv;
   logic [1:0] rr;
   always #2 aclk = ~aclk;
   asrt_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
      .rxd(rxd), .txd(txd), .rx_irq(rx_irq), .tx_irq(tx_irq), .sync_mode(sync_mode));
   asrt_line_model #(.BIT(16)) u_line (.aclk(aclk), .txd(txd), .rxd(rxd));
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
         fail_count++;
      end
   endtask : chk
   task automatic tmo(input logic ok);
      chk(32'(ok), 32'h1);
      if (ok !== 1'b1) conclude();
   endtask : tmo
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int n = 0;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= s;
      req.bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 200);
      req.bready <= 1'b0;
      tmo(rsp.bvalid);
   endtask : wr
   task automatic rd(input logic [31:0] a);
      int n = 0;
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 200);
      rv = rsp.rdata;
      rr = rsp.rresp;
      req.rready <= 1'b0;
      tmo(rsp.rvalid);
   endtask : rd
   task automatic rck(input logic [31:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask : rck
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wr(`ASRT_OFF_DIV, 32'h1, 4'h3);
   endtask : do_reset
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // start bit, data lsb first, optional parity, stop
   function automatic logic [11:0] frame(input logic [7:0] ch, input int nb, input logic pon,
      input logic pb, input logic stp, output int n);
      logic [11:0] f;
      f = 12'hffe;
      for (int i = 0; i < nb; i++) f[i + 1] = ch[i];
      n = nb + 1;
      if (pon) begin
         f[n] = pb;
         n++;
      end
      f[n] = stp;
      n++;
      return f;
   endfunction : frame
   initial begin
      logic [1:0] len;
      logic pen, pev, pon, pb, gp, bp, bs;
      logic [7:0] cm;
      logic [11:0] fr;
      logic [31:0] ex;
      int nb, n, c0, w;
      do_reset();
      rck(`ASRT_OFF_TX_CTRL, 32'h80);
      rck(`ASRT_OFF_RX_CTRL, 32'h0);
      rd(32'h40);
      chk(rv, 32'h0);
      chk(32'(rr), 32'(`ASRT_RESP_ERR));
      $display("test reset finished");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         len = 2'(i);
         pen = i[2];
         pev = rnd[8];
         bp = (i == 5) | rnd[9];
         bs = (i == 2) | (i == 6) | (rnd[10] & rnd[11]);
         nb = 5 + i % 4;
         cm = 8'((16'h1 << nb) - 1) & rnd[7:0];
         pon = pen && nb < 8;
         gp = pev ? ^cm : ~(^cm);
         pb = gp ^ bp;
         wr(`ASRT_OFF_LINE, {28'h0, pev, pen, len}, 4'h1);
         fr = frame(cm, nb, pon, pb, !bs, n);
         u_line.send(fr, n);
         repeat (4) @(posedge aclk);
         ex = {16'h0, bs | (pon & bp), 1'b0, bs, pon & bp, 4'h0, cm};
         if (pon) ex[nb] = pb;
         chk(32'(rx_irq), 32'h0);
         rck(`ASRT_OFF_RX_BUF, ex);
         rck(`ASRT_OFF_RX_CTRL, 32'h0);
         rck(`ASRT_OFF_RX_BUF, ex & 32'h0fff);
      end
      $display("test receive finished");
      wr(`ASRT_OFF_LINE, 32'h3, 4'h1);
      wr(`ASRT_OFF_RX_CTRL, 32'h40, 4'h1);
      u_line.send(12'h5a5 << 1, 10);
      repeat (4) @(posedge aclk);
      chk(32'(rx_irq), 32'h1);
      rck(`ASRT_OFF_RX_CTRL, 32'hc0);
      rd(`ASRT_OFF_RX_BUF);
      repeat (4) @(posedge aclk);
      chk(32'(rx_irq), 32'h0);
      for (int j = 0; j < 2; j++) begin
         u_line.send(12'h33c, 10);
         repeat (16) @(posedge aclk);
         u_line.send({3'h7, rnd[7:0], 1'b0}, 10);
         repeat (4) @(posedge aclk);
         if (j == 1) do_reset();
         rck(`ASRT_OFF_RX_BUF, {16'h0, j == 0, j == 0, 6'h0, rnd[7:0]});
      end
      $display("test overrun finished");
      wr(`ASRT_OFF_TX_CTRL, 32'h40, 4'h1);
      repeat (4) @(posedge aclk);
      chk(32'(tx_irq), 32'h1);
      rck(`ASRT_OFF_TX_CTRL, 32'hc0);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         nb = 5 + i;
         cm = 8'((16'h1 << nb) - 1) & rnd[7:0];
         pon = nb < 8;
         gp = rnd[8] ? ^cm : ~(^cm);
         wr(`ASRT_OFF_LINE, {28'h0, rnd[8], 1'b1, 2'(i)}, 4'h1);
         fr = frame(cm, nb, pon, gp, 1'b1, n);
         u_line.rx_len = n - 1;
         c0 = u_line.got_n;
         wr(`ASRT_OFF_TX_BUF, {24'h0, cm}, 4'h1);
         w = 0;
         while (u_line.got_n == c0 && w < 400) begin
            @(posedge aclk);
            w++;
         end
         tmo(u_line.got_n != c0);
         ex = (32'h1 << (n - 1)) - 1;
         chk(32'(u_line.got) & ex, 32'(fr >> 1) & ex);
      end
      $display("test transmit finished");
      repeat (200) @(posedge aclk);
      wr(`ASRT_OFF_TX_CTRL, 32'h41, 4'h1);
      repeat (3) @(posedge aclk);
      chk(32'(txd), 32'h0);
      repeat (40) @(posedge aclk);
      chk(32'(txd), 32'h0);
      wr(`ASRT_OFF_TX_CTRL, 32'h40, 4'h1);
      repeat (3) @(posedge aclk);
      chk(32'(txd), 32'h1);
      $display("test break finished");
      repeat (200) @(posedge aclk);
      wr(`ASRT_OFF_RX_CTRL, 32'h40, 4'h1);
      wr(`ASRT_OFF_LINE, 32'h13, 4'h1);
      repeat (2) @(posedge aclk);
      chk(32'(sync_mode), 32'h1);
      // enables drop here with no priority step, the requests are plain levels
      wr(`ASRT_OFF_LINE, 32'h113, 4'h3);
      repeat (4) @(posedge aclk);
      chk(32'(sync_mode), 32'h0);
      rck(`ASRT_OFF_RX_CTRL, 32'h0);
      rck(`ASRT_OFF_TX_CTRL, 32'h80);
      $display("test programmed reset finished");
      conclude();
   end
endmodule : tb_top
